// ==== dual_timer_params.svh ====
/*
  Register indices, field positions and reset values of the dual timer.
  Assumes a Wishbone byte address whose bits 7:2 carry the register index.
*/
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH

`define DT_IDX_IRQ_EN 6'h00
`define DT_IDX_IRQ_FLAG 6'h01
`define DT_IDX_A_PRESCALE 6'h02
`define DT_IDX_B_PRESCALE 6'h03
`define DT_IDX_A_LOW 6'h04
`define DT_IDX_A_HIGH 6'h05
`define DT_IDX_B_LOW 6'h06
`define DT_IDX_B_HIGH 6'h07
`define DT_IDX_B_CONTROL 6'h13

`define DT_BIT_IRQ_A 0
`define DT_BIT_IRQ_B 1
`define DT_BIT_SOURCE 3
`define DT_BIT_POLARITY 3
`define DT_BIT_RUN 3
`define DT_BIT_DUAL 2
`define DT_BIT_MODE 0

`define DT_RST_NIBBLE 4'h0
`define DT_RST_BYTE 8'h00
`define DT_RST_PRESCALE 11'h000

`endif

// ==== dual_timer_pkg.sv ====
/*
  Types shared by the dual timer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dual_timer_pkg;
   typedef enum logic [3:0] {
      MEAS_IDLE = 4'b0001,
      MEAS_WAIT = 4'b0010,
      MEAS_COUNT = 4'b0100,
      MEAS_SECOND = 4'b1000
   } meas_state_type;
endpackage

// ==== dual_timer_pulse_capture.sv ====
/*
  Two 8-bit auto-reload timers with nibble access over classic Wishbone;
  timer_b can measure pulse widths on a capture pin.
  Assumes clk is the system clock (oscillator / 4) and that the pins are
  asynchronous to it.
*/
`include "dual_timer_params.svh"

// How it works
// - Timer_a reload and counter, nibble accessed
// - Reload on high-nibble write and on wrap
// - High-nibble read latches low nibble for coherence
// - Timer_a counts up, flags overflow
// - Three-bit divider selects timer_a prescale
// - Source bit picks clock or falling pin
// - External count input synchronised, prescaled likewise
// - Mode bit picks timer or pulse measurement
// - Run bit starts/stops, reads state, resets stopped
// - Timer_b loads, runs, interrupts when enabled
// - Count writes ignored while timer_b runs
// - Three-bit divider selects timer_b prescale
// - Polarity bit picks rising or falling trigger
// - Setting run with measurement mode already set clears counter; trigger starts it
// - Opposite edge captures count and interrupts
// - Single-edge: capture then clear and halt
// - Dual-edge: keep running, recapture on trigger
// - Measurement ignores count register writes
// - Count register writes reload; reads count, or capture in measurement mode
// - System clock is oscillator divided by four
// - Mode bit selects pin function
module dual_timer_pulse_capture #(
   parameter int CNT_WIDTH = 8,
   parameter int PRE_WIDTH = 11
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Wishbone slave
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck,
   // Pins
   input wire logic extCountPin,
   input wire logic capturePin,
   // Pin function selects and interrupts
   output logic extCountSelect,
   output logic captureSelect,
   output logic irqA,
   output logic irqB
);
   if (CNT_WIDTH != 8 || PRE_WIDTH != 11) begin : gCheck
      $error("Nibble map needs an 8-bit counter and an 11-bit prescaler");
   end

   // Prescale tick: the selected low bits of a free counter are all ones
   function automatic logic divTick(input logic [2:0] sel, input logic [10:0] pre);
      logic [10:0] mask;
      mask = 11'h000;
      unique case (sel)
         3'h0: mask = 11'h7ff;
         3'h1: mask = 11'h1ff;
         3'h2: mask = 11'h07f;
         3'h3: mask = 11'h01f;
         3'h4: mask = 11'h007;
         3'h5: mask = 11'h003;
         3'h6: mask = 11'h001;
         3'h7: mask = 11'h000;
      endcase
      return (pre & mask) == mask;
   endfunction

   // Bus state
   logic ack_r, ack_nxt;
   logic [31:0] datR_r, datR_nxt;
   logic [1:0] irqEn_r, irqEn_nxt;
   logic [1:0] flag_r, flag_nxt;
   logic [3:0] selA_r, selA_nxt;
   logic [3:0] selB_r, selB_nxt;
   logic runB_r, runB_nxt;
   logic dualB_r, dualB_nxt;
   logic modeB_r, modeB_nxt;
   logic [3:0] shadowA_r, shadowA_nxt;
   logic [3:0] shadowB_r, shadowB_nxt;
   logic irqA_r, irqA_nxt;
   logic irqB_r, irqB_nxt;
   // Pin synchronisers
   logic [2:0] extSync_r;
   logic [2:0] capSync_r;
   // Timer_a state
   logic [10:0] preA_r, preA_nxt;
   logic [7:0] cntA_r, cntA_nxt;
   logic [7:0] reloadA_r, reloadA_nxt;
   // Timer_b state
   logic [10:0] preB_r, preB_nxt;
   logic [7:0] cntB_r, cntB_nxt;
   logic [7:0] reloadB_r, reloadB_nxt;
   logic [7:0] capB_r, capB_nxt;
   dual_timer_pkg::meas_state_type measState_r, measState_nxt;

   logic req, wr, rd;
   logic [5:0] idx;
   logic [3:0] wd;
   logic wrAHi, wrALo, wrBHi, wrBLo, wrCtl, runSet;
   logic advA, tickA, ovfA, tickB, evtB;
   logic extFall, capRise, capFall, trig, opp;
   logic [7:0] valB;

   // Request decode: writes take effect at the edge that raises ack
   always_comb begin
      req = wbCyc && wbStb && !ack_r;
      wr = req && wbWe && wbSel[0];
      rd = req && !wbWe;
      idx = wbAdr[7:2];
      wd = wbDatW[3:0];
      wrALo = wr && idx == `DT_IDX_A_LOW;
      wrAHi = wr && idx == `DT_IDX_A_HIGH;
      wrBLo = wr && idx == `DT_IDX_B_LOW;
      wrBHi = wr && idx == `DT_IDX_B_HIGH;
      wrCtl = wr && idx == `DT_IDX_B_CONTROL;
      runSet = wrCtl && wd[`DT_BIT_RUN] && !runB_r;
      valB = modeB_r ? capB_r : cntB_r;
   end

   // Edges look only at the second and third stages; the first feeds nothing else
   always_comb begin
      extFall = extSync_r[2] && !extSync_r[1];
      capRise = !capSync_r[2] && capSync_r[1];
      capFall = capSync_r[2] && !capSync_r[1];
      trig = modeB_r && (selB_r[`DT_BIT_POLARITY] ? capRise : capFall);
      opp = modeB_r && (selB_r[`DT_BIT_POLARITY] ? capFall : capRise);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         extSync_r <= 3'h0;
         capSync_r <= 3'h0;
      end else begin
         extSync_r <= {extSync_r[1:0], extCountPin};
         capSync_r <= {capSync_r[1:0], capturePin};
      end
   end

   // Register file
   always_comb begin
      ack_nxt = req;
      datR_nxt = datR_r;
      irqEn_nxt = irqEn_r;
      selA_nxt = selA_r;
      selB_nxt = selB_r;
      runB_nxt = runB_r;
      dualB_nxt = dualB_r;
      modeB_nxt = modeB_r;
      shadowA_nxt = shadowA_r;
      shadowB_nxt = shadowB_r;
      flag_nxt = flag_r;
      if (wr) begin
         unique case (idx)
            `DT_IDX_IRQ_EN: irqEn_nxt = wd[1:0];
            `DT_IDX_IRQ_FLAG: flag_nxt = flag_r & ~wd[1:0];
            `DT_IDX_A_PRESCALE: selA_nxt = wd;
            `DT_IDX_B_PRESCALE: selB_nxt = wd;
            `DT_IDX_B_CONTROL: begin
               runB_nxt = wd[`DT_BIT_RUN];
               dualB_nxt = wd[`DT_BIT_DUAL];
               modeB_nxt = wd[`DT_BIT_MODE];
            end
            default: ;
         endcase
      end
      // Hardware sets win over a clear in the same cycle
      if (ovfA) begin
         flag_nxt[`DT_BIT_IRQ_A] = 1'b1;
      end
      if (evtB) begin
         flag_nxt[`DT_BIT_IRQ_B] = 1'b1;
      end
      if (rd) begin
         datR_nxt = 32'h0;
         unique case (idx)
            `DT_IDX_IRQ_EN: datR_nxt[1:0] = irqEn_r;
            `DT_IDX_IRQ_FLAG: datR_nxt[1:0] = flag_r;
            `DT_IDX_A_PRESCALE: datR_nxt[3:0] = selA_r;
            `DT_IDX_B_PRESCALE: datR_nxt[3:0] = selB_r;
            `DT_IDX_A_HIGH: begin
               datR_nxt[3:0] = cntA_r[7:4];
               shadowA_nxt = cntA_r[3:0];
            end
            `DT_IDX_A_LOW: datR_nxt[3:0] = shadowA_r;
            `DT_IDX_B_HIGH: begin
               datR_nxt[3:0] = valB[7:4];
               shadowB_nxt = valB[3:0];
            end
            `DT_IDX_B_LOW: datR_nxt[3:0] = shadowB_r;
            `DT_IDX_B_CONTROL: datR_nxt[3:0] = {runB_r, dualB_r, 1'b0, modeB_r};
            default: datR_nxt = 32'h0;
         endcase
      end
      irqA_nxt = flag_nxt[`DT_BIT_IRQ_A] && irqEn_nxt[`DT_BIT_IRQ_A];
      irqB_nxt = flag_nxt[`DT_BIT_IRQ_B] && irqEn_nxt[`DT_BIT_IRQ_B];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ack_r <= 1'b0;
         datR_r <= 32'h0;
         irqEn_r <= 2'h0;
         flag_r <= 2'h0;
         selA_r <= `DT_RST_NIBBLE;
         selB_r <= `DT_RST_NIBBLE;
         runB_r <= 1'b0;
         dualB_r <= 1'b0;
         modeB_r <= 1'b0;
         shadowA_r <= `DT_RST_NIBBLE;
         shadowB_r <= `DT_RST_NIBBLE;
         irqA_r <= 1'b0;
         irqB_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
         datR_r <= datR_nxt;
         irqEn_r <= irqEn_nxt;
         flag_r <= flag_nxt;
         selA_r <= selA_nxt;
         selB_r <= selB_nxt;
         runB_r <= runB_nxt;
         dualB_r <= dualB_nxt;
         modeB_r <= modeB_nxt;
         shadowA_r <= shadowA_nxt;
         shadowB_r <= shadowB_nxt;
         irqA_r <= irqA_nxt;
         irqB_r <= irqB_nxt;
      end
   end

   // Timer_a: the prescaler advances on clk or on each synced falling pin edge
   always_comb begin
      advA = selA_r[`DT_BIT_SOURCE] ? extFall : 1'b1;
      tickA = advA && divTick(selA_r[2:0], preA_r);
      preA_nxt = advA ? preA_r + 11'h001 : preA_r;
      reloadA_nxt = reloadA_r;
      cntA_nxt = cntA_r;
      ovfA = 1'b0;
      if (wrALo) begin
         reloadA_nxt[3:0] = wd;
      end
      if (wrAHi) begin
         reloadA_nxt[7:4] = wd;
         cntA_nxt = {wd, reloadA_r[3:0]};
      end else if (tickA) begin
         if (cntA_r == 8'hff) begin
            cntA_nxt = reloadA_r;
            ovfA = 1'b1;
         end else begin
            cntA_nxt = cntA_r + 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         preA_r <= `DT_RST_PRESCALE;
         cntA_r <= `DT_RST_BYTE;
         reloadA_r <= `DT_RST_BYTE;
      end else begin
         preA_r <= preA_nxt;
         cntA_r <= cntA_nxt;
         reloadA_r <= reloadA_nxt;
      end
   end

   // Timer_b: interval timer or pulse measurement
   always_comb begin
      tickB = divTick(selB_r[2:0], preB_r);
      preB_nxt = preB_r + 11'h001;
      reloadB_nxt = reloadB_r;
      cntB_nxt = cntB_r;
      capB_nxt = capB_r;
      measState_nxt = measState_r;
      evtB = 1'b0;
      if (wrBLo) begin
         reloadB_nxt[3:0] = wd;
      end
      if (wrBHi) begin
         reloadB_nxt[7:4] = wd;
      end
      if (!modeB_r) begin
         measState_nxt = dual_timer_pkg::MEAS_IDLE;
         // A running timer ignores count writes
         if (wrBHi && !runB_r) begin
            cntB_nxt = {wd, reloadB_r[3:0]};
         end else if (runB_r && tickB) begin
            if (cntB_r == 8'hff) begin
               cntB_nxt = reloadB_r;
               evtB = 1'b1;
            end else begin
               cntB_nxt = cntB_r + 8'h01;
            end
         end
      end else if (runSet) begin
         cntB_nxt = 8'h00;
         measState_nxt = dual_timer_pkg::MEAS_WAIT;
      end else if (!runB_r) begin
         measState_nxt = dual_timer_pkg::MEAS_IDLE;
      end else begin
         unique case (measState_r)
            dual_timer_pkg::MEAS_IDLE: measState_nxt = dual_timer_pkg::MEAS_WAIT;
            dual_timer_pkg::MEAS_WAIT: begin
               if (trig) begin
                  measState_nxt = dual_timer_pkg::MEAS_COUNT;
               end
            end
            dual_timer_pkg::MEAS_COUNT: begin
               if (opp) begin
                  capB_nxt = cntB_r;
                  evtB = 1'b1;
                  if (dualB_r) begin
                     measState_nxt = dual_timer_pkg::MEAS_SECOND;
                  end else begin
                     cntB_nxt = 8'h00;
                     measState_nxt = dual_timer_pkg::MEAS_WAIT;
                  end
               end else if (tickB) begin
                  cntB_nxt = cntB_r + 8'h01;
               end
            end
            dual_timer_pkg::MEAS_SECOND: begin
               if (trig) begin
                  capB_nxt = cntB_r;
                  evtB = 1'b1;
                  cntB_nxt = 8'h00;
                  measState_nxt = dual_timer_pkg::MEAS_COUNT;
               end else if (tickB) begin
                  cntB_nxt = cntB_r + 8'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         preB_r <= `DT_RST_PRESCALE;
         cntB_r <= `DT_RST_BYTE;
         reloadB_r <= `DT_RST_BYTE;
         capB_r <= `DT_RST_BYTE;
         measState_r <= dual_timer_pkg::MEAS_IDLE;
      end else begin
         preB_r <= preB_nxt;
         cntB_r <= cntB_nxt;
         reloadB_r <= reloadB_nxt;
         capB_r <= capB_nxt;
         measState_r <= measState_nxt;
      end
   end

   assign wbAck = ack_r;
   assign wbDatR = datR_r;
   assign extCountSelect = selA_r[`DT_BIT_SOURCE];
   assign captureSelect = modeB_r;
   assign irqA = irqA_r;
   assign irqB = irqB_r;

   // Checks
   ack_one_cycle_a: assert property (@(posedge clk) disable iff (srst)
      ack_r |=> !ack_r) else $error("ack held longer than one cycle");
   ack_latency_a: assert property (@(posedge clk) disable iff (srst)
      (wbCyc && wbStb && !ack_r) |=> ack_r) else $error("ack missing");
   a_wrap_reload_a: assert property (@(posedge clk) disable iff (srst)
      (tickA && cntA_r == 8'hff && !wrAHi) |=> (cntA_r == $past(reloadA_r) && flag_r[0]))
      else $error("timer_a wrap did not reload and flag");
   run_reset_a: assert property (@(posedge clk)
      srst |=> !runB_r) else $error("run bit not cleared by reset");
   b_load_block_a: assert property (@(posedge clk) disable iff (srst)
      (wrBHi && runB_r && !modeB_r && !tickB) |=> cntB_r == $past(cntB_r))
      else $error("running timer_b took a count write");
   // A start that stays in measurement mode leaves the counter at zero for the next two cycles
   meas_clear_a: assert property (@(posedge clk) disable iff (srst)
      (modeB_r && runSet && wd[`DT_BIT_MODE]) |=> (cntB_r == 8'h00 ##1 cntB_r == 8'h00))
      else $error("measurement start did not clear counter");
   capture_copy_a: assert property (@(posedge clk) disable iff (srst)
      (modeB_r && runB_r && !wrCtl && measState_r == dual_timer_pkg::MEAS_COUNT && opp)
      |=> (capB_r == $past(cntB_r) && flag_r[1]))
      else $error("opposite edge did not capture");
   single_halt_a: assert property (@(posedge clk) disable iff (srst)
      (modeB_r && runB_r && !wrCtl && !dualB_r
       && measState_r == dual_timer_pkg::MEAS_COUNT && opp)
      |=> (cntB_r == 8'h00 && measState_r == dual_timer_pkg::MEAS_WAIT))
      else $error("single-edge capture did not halt");
endmodule

// ==== pin_source.sv ====
/*
  External count source and capture pulse source for the dual timer pins.
  Assumes the bench calls each task from one process at a time.
*/
module pin_source (
   // Clock
   input wire logic clk,
   // Pins
   output logic countPin,
   output logic capPin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      countPin = 1'b1;
      capPin = 1'b0;
   end

   // Each level held at least four clocks so the three-flop synchroniser never misses one
   task automatic count_falls(input int n);
      repeat (n) begin
         @(posedge clk) countPin <= 1'b0;
         repeat (4) @(posedge clk);
         countPin <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask

   // Holds the capture pin at a level for a number of clocks
   task automatic cap_hold(input logic v, input int w);
      @(posedge clk) capPin <= v;
      repeat (w - 1) @(posedge clk);
   endtask
endmodule

// ==== testbench.sv ====
/*
  Self-checking bench for the dual timer with pulse capture.
  Assumes the design answers each Wishbone request with a one-cycle ack.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, srst, wbCyc, wbStb, wbWe, wbAck, extCountPin, capturePin;
   logic extCountSelect, captureSelect, irqA, irqB;
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [3:0] selUse;
   logic [31:0] wbDatW, wbDatR;
   int fail_count, n_tests;

   dual_timer_pulse_capture #(.CNT_WIDTH(8), .PRE_WIDTH(11)) DUT (
      .clk(clk), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
      .extCountPin(extCountPin), .capturePin(capturePin),
      .extCountSelect(extCountSelect), .captureSelect(captureSelect),
      .irqA(irqA), .irqB(irqB));

   pin_source PINS (.clk(clk), .countPin(extCountPin), .capPin(capturePin));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Request held until ack is seen; released only at that edge
   task automatic bus(input logic we, input logic [5:0] idx, input logic [3:0] d,
                      output logic [3:0] q);
      int t;
      t = 0;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= {idx, 2'b00};
      wbDatW <= {28'h0000000, d};
      wbSel <= selUse;
      do begin
         @(posedge clk);
         t++;
      end while (wbAck !== 1'b1 && t < 20);
      if (t >= 20) fail_count++;
      q = wbDatR[3:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [3:0] d);
      logic [3:0] q;
      bus(1'b1, idx, d, q);
   endtask

   task automatic rd(input logic [5:0] idx, output logic [7:0] v);
      logic [3:0] q;
      bus(1'b0, idx, 4'h0, q);
      v = {4'h0, q};
   endtask

   // High nibble first so the low read returns the latched half
   task automatic rd8(input logic [5:0] hi, output logic [7:0] v);
      logic [3:0] h, l;
      bus(1'b0, hi, 4'h0, h);
      bus(1'b0, hi - 6'h01, 4'h0, l);
      v = {h, l};
   endtask

   task automatic t_reset;
      logic [7:0] v;
      rd(6'h13, v);
      chk(v, 8'h00);
      rd(6'h03, v);
      chk(v, 8'h00);
      rd(6'h02, v);
      chk(v, 8'h00);
      selUse = 4'he;
      wr(6'h02, 4'hf);
      selUse = 4'hf;
      rd(6'h02, v);
      chk(v, 8'h00);
      rd(6'h3f, v);
      chk(v, 8'h00);
   endtask

   task automatic t_timer_a;
      logic [7:0] v;
      wr(6'h02, 4'hf);
      chk({7'h00, extCountSelect}, 8'h01);
      wr(6'h04, 4'he);
      wr(6'h05, 4'hf);
      rd8(6'h05, v);
      chk(v, 8'hfe);
      PINS.count_falls(2);
      rd8(6'h05, v);
      chk(v, 8'hfe);
      rd(6'h01, v);
      chk(v, 8'h01);
      chk({7'h00, irqA}, 8'h00);
      wr(6'h00, 4'h1);
      repeat (3) @(posedge clk);
      chk({7'h00, irqA}, 8'h01);
      wr(6'h01, 4'h1);
      repeat (3) @(posedge clk);
      chk({7'h00, irqA}, 8'h00);
      wr(6'h02, 4'he);
      wr(6'h04, 4'h0);
      wr(6'h05, 4'h1);
      PINS.count_falls(4);
      rd8(6'h05, v);
      chk(v, 8'h12);
      // System clock at divide by 8: 83 clocks pass from load to the latching read
      wr(6'h02, 4'h4);
      chk({7'h00, extCountSelect}, 8'h00);
      wr(6'h04, 4'h0);
      wr(6'h05, 4'h0);
      repeat (80) @(posedge clk);
      rd8(6'h05, v);
      chk({7'h00, v == 8'h0a || v == 8'h0b}, 8'h01);
      wr(6'h02, 4'h8);
   endtask

   task automatic t_timer_b;
      logic [7:0] v;
      wr(6'h03, 4'h0);
      wr(6'h06, 4'ha);
      wr(6'h07, 4'h5);
      rd8(6'h07, v);
      chk(v, 8'h5a);
      wr(6'h13, 4'h8);
      rd(6'h13, v);
      chk(v, 8'h08);
      wr(6'h06, 4'h1);
      wr(6'h07, 4'h1);
      wr(6'h13, 4'h0);
      rd8(6'h07, v);
      chk({7'h00, v == 8'h5a || v == 8'h5b}, 8'h01);
      wr(6'h07, 4'h1);
      rd8(6'h07, v);
      chk(v, 8'h11);
      wr(6'h03, 4'h7);
      wr(6'h06, 4'hf);
      wr(6'h07, 4'hf);
      wr(6'h00, 4'h2);
      wr(6'h13, 4'h8);
      rd(6'h01, v);
      chk(v, 8'h02);
      chk({7'h00, irqB}, 8'h01);
      wr(6'h13, 4'h0);
      wr(6'h01, 4'h2);
      repeat (3) @(posedge clk);
      chk({7'h00, irqB}, 8'h00);
   endtask

   // Trigger 30, opposite 20, trigger 10; only the dual mode captures on the trigger
   task automatic t_measure(input logic pol, input logic dual);
      logic [7:0] v;
      int e;
      e = dual ? 50 : 30;
      wr(6'h03, {pol, 3'h7});
      PINS.cap_hold(~pol, 6);
      wr(6'h13, {1'b0, dual, 2'b01});
      wr(6'h13, {1'b1, dual, 2'b01});
      chk({7'h00, captureSelect}, 8'h01);
      fork
         begin
            PINS.cap_hold(pol, 30);
            PINS.cap_hold(~pol, 20);
            PINS.cap_hold(pol, 10);
         end
         begin
            repeat (12) @(posedge clk);
            wr(6'h06, 4'h0);
            wr(6'h07, 4'h0);
         end
      join
      rd8(6'h07, v);
      chk({7'h00, v >= e - 2 && v <= e + 2}, 8'h01);
      rd(6'h01, v);
      chk(v, 8'h02);
      chk({7'h00, irqB}, 8'h01);
      wr(6'h13, 4'h0);
      wr(6'h01, 4'h2);
   endtask

   initial begin
      fail_count = 0;
      n_tests = 0;
      srst = 1'b1;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 8'h00;
      wbSel = 4'hf;
      selUse = 4'hf;
      wbDatW = 32'h00000000;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_timer_a;
      t_timer_b;
      t_measure(1'b1, 1'b0);
      t_measure(1'b0, 1'b0);
      t_measure(1'b1, 1'b1);
      tally_and_finish;
   end

   // Whole run needs several hundred clocks
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      tally_and_finish;
   end
endmodule
